/* common/tibc_pkg.sv */
// package for the transmitter interrupt and buffer-control block
// assumes a byte-wide register port with a 7-bit address pointer
package tibc_pkg;
    localparam logic [6:0] ADDR_TX_STATUS = 7'h07;
    localparam logic [6:0] ADDR_UB_STATUS = 7'h08;
    localparam logic [6:0] ADDR_TX_ENABLE = 7'h09;
    localparam logic [6:0] ADDR_TX_TRIG_HI = 7'h0a;
    localparam logic [6:0] ADDR_TX_TRIG_LO = 7'h0b;
    localparam logic [6:0] ADDR_UB_ENABLE = 7'h0c;
    localparam logic [6:0] ADDR_UB_TRIG_HI = 7'h0d;
    localparam logic [6:0] ADDR_UB_TRIG_LO = 7'h0e;
    localparam logic [6:0] ADDR_CS_BUF_CTRL = 7'h12;
    localparam logic [6:0] ADDR_UB_BUF_CTRL = 7'h13;
    localparam logic [6:0] ADDR_WIN_FIRST = 7'h20;
    localparam logic [6:0] ADDR_WIN_LAST = 7'h37;
    localparam logic [6:0] ADDR_IDENTITY = 7'h7f;
    // event bit positions
    localparam int BIT_SLIP = 7;
    localparam int BIT_CS_XFER = 1;
    localparam int BIT_UB_XFER = 2;
    // control field positions
    localparam int BIT_BUF_SEL = 5;
    localparam int BIT_CS_INHIBIT = 2;
    localparam int BIT_CS_WIDTH = 1;
    localparam int BIT_USER_SRC = 4;
    localparam int BIT_UMODE_LO = 2;
    localparam int BIT_UB_INHIBIT = 0;
    // writable bits of each register
    localparam logic [7:0] TX_EVENT_BITS = 8'h82;
    localparam logic [7:0] UB_EVENT_BITS = 8'h04;
    localparam logic [7:0] CS_CTRL_BITS = 8'h26;
    localparam logic [7:0] UB_CTRL_BITS = 8'h1d;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // identity values are arbitrary
    localparam logic [3:0] PART_CODE = 4'h5;
    localparam logic [3:0] REVISION_CODE = 4'h3;
    localparam logic [4:0] BUF_BYTES = 5'h18;

    typedef enum logic [1:0] {TRIG_RISE, TRIG_FALL, TRIG_LEVEL, TRIG_RSVD} tibc_trig_t;
    typedef enum logic [1:0] {POL_HIGH, POL_LOW, POL_OPEN_DRAIN, POL_RSVD} tibc_pol_t;
    typedef enum logic [1:0] {UMODE_ZERO, UMODE_BLOCK, UMODE_RSVD2, UMODE_RSVD3} tibc_umode_t;

    typedef struct packed {
        logic        buffer_select;
        logic        cs_transfer_inhibit;
        logic        cs_access_width;
        logic        user_source_select;
        tibc_umode_t user_manager_mode;
        logic        ub_transfer_inhibit;
    } tibc_ctrl_t;
endpackage : tibc_pkg

/* hdl/tibc_top.sv */
// interrupt status, masks, trigger modes and buffer control of the transmitter
// assumes a control-port front end that hands over one byte access per pulse
`timescale 1ns/1ps
module tibc_top
    import tibc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       addr_load_i,
    input  wire logic [6:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       slip_event_i,
    input  wire logic       block_start_pin_i,
    input  wire logic       block_start_is_input_i,
    input  wire logic       cs_xfer_busy_i,
    input  wire logic       ub_xfer_busy_i,
    input  wire logic       run_i,
    input  wire logic [1:0] irq_pin_polarity_i,
    output logic [7:0]      rdata_o,
    output logic            rvalid_o,
    output logic [6:0]      addr_ptr_o,
    output logic            irq_pin_o,
    output logic            irq_pin_oe_o,
    output logic            buf_wr_o,
    output logic            buf_rd_o,
    output logic            buf_user_o,
    output logic [4:0]      buf_index_o,
    output logic [7:0]      buf_wdata_o,
    output logic            cs_xfer_allow_o,
    output logic            ub_xfer_allow_o,
    output logic            engine_reset_o,
    output tibc_ctrl_t      ctrl_o
);
    logic [6:0] ptr_q;
    logic [7:0] tx_stat_q, ub_stat_q, tx_en_q, tx_hi_q, tx_lo_q, ub_en_q, ub_hi_q, ub_lo_q;
    logic [7:0] cs_ctrl_q, ub_ctrl_q;
    logic [1:0] bs_sync_q, bs_last_q;
    logic [7:0] tx_src_q, ub_src_q;

    // block-start pin is asynchronous: two stages, edge taken across the two further stages after the second
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            bs_sync_q <= 2'b00;
        end else begin
            bs_sync_q <= {bs_sync_q[0], block_start_pin_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            bs_last_q <= 2'b00;
        end else begin
            bs_last_q <= {bs_last_q[0], bs_sync_q[1]};
        end
    end

    wire bs_rise = bs_last_q[0] & ~bs_last_q[1];
    wire umode_block = (ub_ctrl_q[BIT_UMODE_LO+1 -: 2] == 2'(UMODE_BLOCK));

    // raw event sources, one vector per status register
    logic [7:0] tx_src, ub_src;
    always_comb begin
        tx_src = 8'h00;
        ub_src = 8'h00;
        tx_src[BIT_SLIP] = slip_event_i | (block_start_is_input_i & bs_rise);
        tx_src[BIT_CS_XFER] = cs_xfer_busy_i;
        ub_src[BIT_UB_XFER] = ub_xfer_busy_i & umode_block;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_src_q <= 8'h00;
            ub_src_q <= 8'h00;
        end else begin
            tx_src_q <= tx_src;
            ub_src_q <= ub_src;
        end
    end

    function automatic logic [7:0] trig_hit(input logic [7:0] cur, input logic [7:0] prev,
                                            input logic [7:0] hi, input logic [7:0] lo);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            case ({hi[i], lo[i]})
                2'(TRIG_RISE):  r[i] = cur[i] & ~prev[i];
                2'(TRIG_FALL):  r[i] = ~cur[i] & prev[i];
                2'(TRIG_LEVEL): r[i] = cur[i];
                default:        r[i] = 1'b0;
            endcase
        end
        return r;
    endfunction : trig_hit

    function automatic logic [7:0] level_hold(input logic [7:0] cur, input logic [7:0] hi,
                                              input logic [7:0] lo);
        return cur & hi & ~lo;
    endfunction : level_hold

    wire [7:0] tx_hit = trig_hit(tx_src, tx_src_q, tx_hi_q, tx_lo_q);
    wire [7:0] ub_hit = trig_hit(ub_src, ub_src_q, ub_hi_q, ub_lo_q);

    // register port decode
    wire in_window = (ptr_q >= ADDR_WIN_FIRST) && (ptr_q <= ADDR_WIN_LAST);
    wire access = wr_i | rd_i;
    wire rd_tx_stat = rd_i && (ptr_q == ADDR_TX_STATUS);
    wire rd_ub_stat = rd_i && (ptr_q == ADDR_UB_STATUS);
    wire buf_sel = cs_ctrl_q[BIT_BUF_SEL];
    // window open only while running; user buffer only in block mode
    wire win_ok = in_window && run_i && (!buf_sel || umode_block);

    // a mask write masks status at the same edge, so no masked bit is ever visible
    wire [7:0] tx_en_now = (wr_i && (ptr_q == ADDR_TX_ENABLE)) ? (wdata_i & TX_EVENT_BITS) : tx_en_q;
    wire [7:0] ub_en_now = (wr_i && (ptr_q == ADDR_UB_ENABLE)) ? (wdata_i & UB_EVENT_BITS) : ub_en_q;

    // sticky status: an event wins over the read clear
    wire [7:0] tx_stat_d = ((rd_tx_stat ? level_hold(tx_src, tx_hi_q, tx_lo_q) : tx_stat_q) | tx_hit) & tx_en_now;
    wire [7:0] ub_stat_d = ((rd_ub_stat ? level_hold(ub_src, ub_hi_q, ub_lo_q) : ub_stat_q) | ub_hit) & ub_en_now;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_stat_q <= RESET_BYTE;
            ub_stat_q <= RESET_BYTE;
        end else begin
            tx_stat_q <= tx_stat_d;
            ub_stat_q <= ub_stat_d;
        end
    end

    // only writable registers listed; status and identity have no write path
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_en_q <= RESET_BYTE;
            tx_hi_q <= RESET_BYTE;
            tx_lo_q <= RESET_BYTE;
            ub_en_q <= RESET_BYTE;
            ub_hi_q <= RESET_BYTE;
            ub_lo_q <= RESET_BYTE;
            cs_ctrl_q <= RESET_BYTE;
            ub_ctrl_q <= RESET_BYTE;
        end else if (wr_i) begin
            case (ptr_q)
                ADDR_TX_ENABLE:   tx_en_q <= wdata_i & TX_EVENT_BITS;
                ADDR_TX_TRIG_HI:  tx_hi_q <= wdata_i & TX_EVENT_BITS;
                ADDR_TX_TRIG_LO:  tx_lo_q <= wdata_i & TX_EVENT_BITS;
                ADDR_UB_ENABLE:   ub_en_q <= wdata_i & UB_EVENT_BITS;
                ADDR_UB_TRIG_HI:  ub_hi_q <= wdata_i & UB_EVENT_BITS;
                ADDR_UB_TRIG_LO:  ub_lo_q <= wdata_i & UB_EVENT_BITS;
                ADDR_CS_BUF_CTRL: cs_ctrl_q <= wdata_i & CS_CTRL_BITS;
                ADDR_UB_BUF_CTRL: ub_ctrl_q <= wdata_i & UB_CTRL_BITS;
                default:          ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ptr_q <= 7'h00;
        end else if (addr_load_i) begin
            ptr_q <= addr_i;
        end else if (access) begin
            ptr_q <= ptr_q + 7'h01;
        end
    end

    // pointer visible to the port front end
    assign addr_ptr_o = ptr_q;

    // read mux; buffer data itself comes from the buffer engine, not here
    logic [7:0] rmux;
    always_comb begin
        case (ptr_q)
            ADDR_TX_STATUS:   rmux = tx_stat_q;
            ADDR_UB_STATUS:   rmux = ub_stat_q;
            ADDR_TX_ENABLE:   rmux = tx_en_q;
            ADDR_TX_TRIG_HI:  rmux = tx_hi_q;
            ADDR_TX_TRIG_LO:  rmux = tx_lo_q;
            ADDR_UB_ENABLE:   rmux = ub_en_q;
            ADDR_UB_TRIG_HI:  rmux = ub_hi_q;
            ADDR_UB_TRIG_LO:  rmux = ub_lo_q;
            ADDR_CS_BUF_CTRL: rmux = cs_ctrl_q;
            ADDR_UB_BUF_CTRL: rmux = ub_ctrl_q;
            ADDR_IDENTITY:    rmux = {PART_CODE, REVISION_CODE};
            default:          rmux = 8'h00;
        endcase
    end

    // pin: any enabled status, level or enable per polarity
    wire irq_any = |tx_stat_d | |ub_stat_d;
    logic irq_lvl, irq_oe;
    always_comb begin
        case (irq_pin_polarity_i)
            2'(POL_HIGH):       begin irq_lvl = irq_any;  irq_oe = 1'b1;    end
            2'(POL_LOW):        begin irq_lvl = ~irq_any; irq_oe = 1'b1;    end
            2'(POL_OPEN_DRAIN): begin irq_lvl = 1'b0;     irq_oe = irq_any; end
            default:            begin irq_lvl = 1'b0;     irq_oe = 1'b0;    end
        endcase
    end

    tibc_ctrl_t ctrl_d;
    always_comb begin
        ctrl_d.buffer_select       = cs_ctrl_q[BIT_BUF_SEL];
        ctrl_d.cs_transfer_inhibit = cs_ctrl_q[BIT_CS_INHIBIT];
        ctrl_d.cs_access_width     = cs_ctrl_q[BIT_CS_WIDTH];
        ctrl_d.user_source_select  = ub_ctrl_q[BIT_USER_SRC];
        ctrl_d.user_manager_mode   = tibc_umode_t'(ub_ctrl_q[BIT_UMODE_LO+1 -: 2]);
        ctrl_d.ub_transfer_inhibit = ub_ctrl_q[BIT_UB_INHIBIT];
    end

    wire [6:0] win_off = ptr_q - ADDR_WIN_FIRST;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
            irq_pin_o <= 1'b0;
            irq_pin_oe_o <= 1'b0;
            buf_wr_o <= 1'b0;
            buf_rd_o <= 1'b0;
            buf_user_o <= 1'b0;
            buf_index_o <= 5'h00;
            buf_wdata_o <= 8'h00;
            cs_xfer_allow_o <= 1'b0;
            ub_xfer_allow_o <= 1'b0;
            engine_reset_o <= 1'b1;
            ctrl_o <= '0;
        end else begin
            rdata_o <= rd_i ? rmux : rdata_o;
            rvalid_o <= rd_i;
            irq_pin_o <= irq_lvl;
            irq_pin_oe_o <= irq_oe;
            buf_wr_o <= wr_i & win_ok;
            buf_rd_o <= rd_i & win_ok;
            buf_user_o <= buf_sel;
            buf_index_o <= win_off[4:0];
            buf_wdata_o <= wdata_i;
            cs_xfer_allow_o <= run_i & ~cs_ctrl_q[BIT_CS_INHIBIT];
            // user transfers only in block mode and not inhibited
            ub_xfer_allow_o <= run_i & umode_block & ~ub_ctrl_q[BIT_UB_INHIBIT];
            engine_reset_o <= ~run_i;
            ctrl_o <= ctrl_d;
        end
    end

    AST_MASKED_ZERO: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ((tx_stat_q & ~tx_en_q) == 8'h00) && ((ub_stat_q & ~ub_en_q) == 8'h00))
        else $error("masked status bit set");
    AST_SLIP_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tx_en_q[BIT_SLIP] && tx_hit[BIT_SLIP] |=> tx_stat_q[BIT_SLIP])
        else $error("slip event not latched");
    AST_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tx_stat_q[BIT_CS_XFER] && !rd_tx_stat && $stable(tx_en_q) |=> tx_stat_q[BIT_CS_XFER])
        else $error("status lost without read");
    AST_READ_CLEAR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_ub_stat && !ub_hit[BIT_UB_XFER] |=> !ub_stat_q[BIT_UB_XFER])
        else $error("user status not cleared on read");
    AST_LEVEL_KEEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_tx_stat && tx_en_q[BIT_CS_XFER] && tx_hi_q[BIT_CS_XFER] && !tx_lo_q[BIT_CS_XFER]
        && cs_xfer_busy_i |=> tx_stat_q[BIT_CS_XFER])
        else $error("live level source cleared");
    AST_FALL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ub_en_q[BIT_UB_XFER] && !ub_hi_q[BIT_UB_XFER] && ub_lo_q[BIT_UB_XFER]
        && $fell(ub_src[BIT_UB_XFER]) |=> ub_stat_q[BIT_UB_XFER])
        else $error("falling edge missed");
    AST_PIN_HIGH: assert property (@(posedge clk_i) disable iff (!rstn_i)
        irq_pin_polarity_i == 2'(POL_HIGH) |=> irq_pin_o == $past(irq_any))
        else $error("pin not following status");
    AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (!rstn_i)
        irq_pin_polarity_i == 2'(POL_OPEN_DRAIN) |=> !irq_pin_o && irq_pin_oe_o == $past(irq_any))
        else $error("open drain drive wrong");
    AST_PTR_STEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
        access && !addr_load_i |=> ptr_q == $past(ptr_q) + 7'h01)
        else $error("pointer did not step");
    AST_STOP_BUF: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !run_i |=> !buf_wr_o && !buf_rd_o)
        else $error("buffer access while stopped");
    AST_ID: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_i && ptr_q == ADDR_IDENTITY |=> rdata_o == {PART_CODE, REVISION_CODE})
        else $error("identity wrong");

    AST_RVALID: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_i |=> rvalid_o)
        else $error("read not answered");
    AST_NO_RVALID: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !rd_i |=> !rvalid_o)
        else $error("spurious read answer");
    AST_LOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        addr_load_i |=> ptr_q == $past(addr_i))
        else $error("pointer load lost");
    AST_ENGINE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        1'b1 |=> engine_reset_o == !$past(run_i))
        else $error("engine reset wrong");
    AST_CS_ALLOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cs_ctrl_q[BIT_CS_INHIBIT] |=> !cs_xfer_allow_o)
        else $error("cs transfer allowed while inhibited");
    // user transfers need block mode, no inhibit
    AST_UB_ALLOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !umode_block || ub_ctrl_q[BIT_UB_INHIBIT] |=> !ub_xfer_allow_o)
        else $error("user transfer allowed wrongly");
    // user source silent outside block mode
    AST_UB_SRC: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !umode_block |=> !ub_src_q[BIT_UB_XFER])
        else $error("user source outside block mode");
    AST_LEVEL_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tx_en_q[BIT_CS_XFER] && tx_hi_q[BIT_CS_XFER] && !tx_lo_q[BIT_CS_XFER] && cs_xfer_busy_i
        && !wr_i |=> tx_stat_q[BIT_CS_XFER])
        else $error("level source not seen");
    AST_POL_LOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
        irq_pin_polarity_i == 2'(POL_LOW) |=> irq_pin_oe_o && irq_pin_o == !$past(irq_any))
        else $error("active low drive wrong");
    AST_POL_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
        irq_pin_polarity_i == 2'(POL_RSVD) |=> !irq_pin_oe_o)
        else $error("pin driven in reserved polarity");
    AST_WIN_IDX: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_i && win_ok |=> buf_wr_o && buf_index_o == $past(win_off[4:0]))
        else $error("window write misplaced");
    AST_WIN_USER: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_i && win_ok |=> buf_user_o == $past(buf_sel))
        else $error("window buffer select wrong");
    AST_CTRL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        1'b1 |=> {ctrl_o.cs_access_width, ctrl_o.user_source_select, ctrl_o.user_manager_mode}
        == {$past(cs_ctrl_q[BIT_CS_WIDTH]), $past(ub_ctrl_q[BIT_USER_SRC -: 3])})
        else $error("control fields wrong");

    COV_SLIP: cover property (@(posedge clk_i) disable iff (!rstn_i) tx_stat_q[BIT_SLIP] ##1 rd_tx_stat);
    COV_UB: cover property (@(posedge clk_i) disable iff (!rstn_i) ub_stat_q[BIT_UB_XFER]);
    COV_WIN: cover property (@(posedge clk_i) disable iff (!rstn_i) buf_wr_o && buf_user_o);
    COV_LEVEL: cover property (@(posedge clk_i) disable iff (!rstn_i) rd_tx_stat && tx_stat_d[BIT_CS_XFER]);
endmodule : tibc_top

/* verif/tb.sv */
// self-checking bench for the interrupt and buffer-control block
// assumes event sources and pins are driven here, register traffic by the model
`timescale 1ns/1ps
module tb
    import tibc_pkg::*;
;
    logic       clk_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       slip_i = 1'b0;
    logic       bs_pin_i = 1'b0;
    logic       bs_in_i = 1'b0;
    logic       cs_busy_i = 1'b0;
    logic       ub_busy_i = 1'b0;
    logic       run_i = 1'b0;
    logic [1:0] pol_i = 2'b00;
    logic       ld, wr, rd, rvalid, irq, irq_oe, bwr, buser, cs_ok, ub_ok, eng_rst;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, bdata, last_data;
    logic [4:0] bidx, last_idx;
    logic       last_user;
    logic       brd;
    logic [6:0] ptr;
    logic [7:0] tmp;
    int         n_rd = 0;
    tibc_ctrl_t ctrl;
    int         n_errors = 0;
    int         checked = 0;
    int         n_wr = 0;
    int         base;
    initial forever #10 clk_i = ~clk_i;
    tibc_top i_tibc_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_load_i(ld), .addr_i(addr), .wr_i(wr),
        .rd_i(rd), .wdata_i(wdata), .slip_event_i(slip_i), .block_start_pin_i(bs_pin_i),
        .block_start_is_input_i(bs_in_i), .cs_xfer_busy_i(cs_busy_i), .ub_xfer_busy_i(ub_busy_i),
        .run_i(run_i), .irq_pin_polarity_i(pol_i), .rdata_o(rdata), .rvalid_o(rvalid), .addr_ptr_o(ptr),
        .irq_pin_o(irq), .irq_pin_oe_o(irq_oe), .buf_wr_o(bwr), .buf_rd_o(brd), .buf_user_o(buser),
        .buf_index_o(bidx), .buf_wdata_o(bdata), .cs_xfer_allow_o(cs_ok), .ub_xfer_allow_o(ub_ok),
        .engine_reset_o(eng_rst), .ctrl_o(ctrl));
    tibc_mcu_model i_tibc_mcu_model (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata), .addr_load_o(ld),
        .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    // buffer-side monitor keeps the last window write
    always @(posedge clk_i) begin
        if (brd === 1'b1) begin
            n_rd <= n_rd + 1;
        end
        if (bwr === 1'b1) begin
            n_wr      <= n_wr + 1;
            last_idx  <= bidx;
            last_user <= buser;
            last_data <= bdata;
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    task wreg(input logic [6:0] a, input logic [7:0] d);
        i_tibc_mcu_model.load(a);
        i_tibc_mcu_model.put(d);
    endtask : wreg
    task rreg(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        i_tibc_mcu_model.load(a);
        i_tibc_mcu_model.get(v);
        chk(v, e);
    endtask : rreg
    task slip_pulse;
        slip_i = 1'b1;
        tick(1);
        slip_i = 1'b0;
        tick(3);
    endtask : slip_pulse
    task final_report;
        $display("checks %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    task t_reset;
        chk({7'h00, eng_rst}, 8'h01);
        for (int i = 0; i < 7; i++) rreg(ADDR_TX_STATUS + 7'(i), RESET_BYTE);
        rreg(ADDR_IDENTITY, {PART_CODE, REVISION_CODE});
        wreg(ADDR_IDENTITY, 8'h00);
        rreg(ADDR_IDENTITY, {PART_CODE, REVISION_CODE});
        wreg(ADDR_TX_STATUS, 8'hff);
        rreg(ADDR_TX_STATUS, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task t_slip;
        wreg(ADDR_TX_ENABLE, 8'h82);
        slip_pulse();
        tick(8);
        chk({7'h00, irq}, 8'h01);
        rreg(ADDR_TX_STATUS, 8'h80);
        tick(2);
        chk({7'h00, irq}, 8'h00);
        rreg(ADDR_TX_STATUS, 8'h00);
        wreg(ADDR_TX_ENABLE, 8'h02);
        slip_pulse();
        chk({7'h00, irq}, 8'h00);
        rreg(ADDR_TX_STATUS, 8'h00);
        $display("test slip done");
    endtask : t_slip
    // level mode on the cs transfer source
    task t_level;
        wreg(ADDR_TX_TRIG_HI, 8'h02);
        cs_busy_i = 1'b1;
        tick(3);
        chk({7'h00, irq}, 8'h01);
        rreg(ADDR_TX_STATUS, 8'h02);
        rreg(ADDR_TX_STATUS, 8'h02);
        cs_busy_i = 1'b0;
        tick(3);
        rreg(ADDR_TX_STATUS, 8'h02);
        rreg(ADDR_TX_STATUS, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wreg(ADDR_TX_TRIG_HI, 8'h00);
        $display("test level done");
    endtask : t_level
    task t_fall;
        wreg(ADDR_TX_ENABLE, 8'h80);
        wreg(ADDR_TX_TRIG_LO, 8'h80);
        slip_i = 1'b1;
        tick(4);
        rreg(ADDR_TX_STATUS, 8'h00);
        slip_i = 1'b0;
        tick(3);
        rreg(ADDR_TX_STATUS, 8'h80);
        wreg(ADDR_TX_TRIG_HI, 8'h80);
        slip_pulse();
        rreg(ADDR_TX_STATUS, 8'h00);
        wreg(ADDR_TX_TRIG_HI, 8'h00);
        wreg(ADDR_TX_TRIG_LO, 8'h00);
        bs_in_i  = 1'b1;
        bs_pin_i = 1'b1;
        tick(6);
        rreg(ADDR_TX_STATUS, 8'h80);
        bs_in_i  = 1'b0;
        bs_pin_i = 1'b0;
        tick(4);
        bs_pin_i = 1'b1;
        tick(6);
        rreg(ADDR_TX_STATUS, 8'h00);
        bs_pin_i = 1'b0;
        $display("test fall done");
    endtask : t_fall
    // pin polarity with an event pending and with none
    task t_pol;
        logic [7:0] exp[3] = '{8'h03, 8'h02, 8'h02};
        slip_pulse();
        for (int p = 0; p < 3; p++) begin
            pol_i = 2'(p);
            tick(2);
            chk({6'h00, irq_oe, irq}, exp[p]);
        end
        pol_i = 2'b11;
        tick(2);
        chk({7'h00, irq_oe}, 8'h00);
        pol_i = 2'b00;
        wreg(ADDR_TX_TRIG_LO, 8'h80);
        chk({7'h00, irq}, 8'h01);
        wreg(ADDR_TX_TRIG_LO, 8'h00);
        rreg(ADDR_TX_STATUS, 8'h80);
        tick(2);
        chk({7'h00, irq}, 8'h00);
        pol_i = 2'b01;
        tick(2);
        chk({7'h00, irq}, 8'h01);
        pol_i = 2'b10;
        tick(2);
        chk({7'h00, irq_oe}, 8'h00);
        pol_i = 2'b00;
        $display("test polarity done");
    endtask : t_pol
    task t_ctrl;
        run_i = 1'b1;
        tick(2);
        chk({7'h00, eng_rst}, 8'h00);
        wreg(ADDR_CS_BUF_CTRL, 8'hff);
        wreg(ADDR_UB_BUF_CTRL, 8'h15);
        tick(2);
        chk({1'b0, ctrl}, 8'h7b);
        chk({6'h00, cs_ok, ub_ok}, 8'h00);
        rreg(ADDR_CS_BUF_CTRL, 8'h26);
        rreg(ADDR_UB_BUF_CTRL, 8'h15);
        wreg(ADDR_CS_BUF_CTRL, 8'h00);
        wreg(ADDR_UB_BUF_CTRL, 8'h04);
        tick(2);
        chk({6'h00, cs_ok, ub_ok}, 8'h03);
        wreg(ADDR_UB_ENABLE, 8'h04);
        ub_busy_i = 1'b1;
        tick(2);
        ub_busy_i = 1'b0;
        tick(3);
        chk({7'h00, irq}, 8'h01);
        rreg(ADDR_UB_STATUS, 8'h04);
        wreg(ADDR_UB_BUF_CTRL, 8'h00);
        ub_busy_i = 1'b1;
        tick(2);
        ub_busy_i = 1'b0;
        tick(3);
        rreg(ADDR_UB_STATUS, 8'h00);
        $display("test control done");
    endtask : t_ctrl
    task t_window;
        wreg(ADDR_UB_BUF_CTRL, 8'h04);
        base = n_wr;
        i_tibc_mcu_model.load(ADDR_WIN_FIRST);
        i_tibc_mcu_model.put(8'haa);
        i_tibc_mcu_model.put(8'hbb);
        tick(2);
        chk({1'b0, ptr}, 8'h22);
        i_tibc_mcu_model.load(ADDR_WIN_FIRST);
        i_tibc_mcu_model.get(tmp);
        tick(2);
        chk(8'(n_rd), 8'h01);
        chk(8'(n_wr - base), 8'h02);
        chk({last_user, 2'b00, last_idx}, 8'h01);
        chk(last_data, 8'hbb);
        wreg(ADDR_CS_BUF_CTRL, 8'h20);
        wreg(ADDR_WIN_LAST, 8'h5c);
        tick(2);
        chk({last_user, 2'b00, last_idx}, 8'h97);
        wreg(ADDR_UB_BUF_CTRL, 8'h00);
        base = n_wr;
        wreg(7'h21, 8'h11);
        tick(2);
        chk(8'(n_wr - base), 8'h00);
        run_i = 1'b0;
        wreg(ADDR_CS_BUF_CTRL, 8'h00);
        wreg(7'h21, 8'h11);
        tick(2);
        chk(8'(n_wr - base), 8'h00);
        chk({7'h00, eng_rst}, 8'h01);
        $display("test window done");
    endtask : t_window
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (16) @(negedge clk_i);
        rstn_i = 1'b1;
        t_reset();
        t_slip();
        t_level();
        t_fall();
        t_pol();
        t_ctrl();
        t_window();
        final_report();
    end
endmodule : tb

/* verif/tibc_mcu_model.sv */
// control-port master model: loads the pointer, writes and reads bytes
// assumes rvalid answers a read strobe one cycle later
`timescale 1ns/1ps
module tibc_mcu_model (
    input  wire logic       clk_i,
    input  wire logic       rvalid_i,
    input  wire logic [7:0] rdata_i,
    output logic            addr_load_o,
    output logic [6:0]      addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      wdata_o
);
    initial begin
        addr_load_o = 1'b0;
        addr_o      = 7'h00;
        wr_o        = 1'b0;
        rd_o        = 1'b0;
        wdata_o     = 8'h00;
    end
    // idle lines show the inverse of the last value so stale data never matches
    task load(input logic [6:0] a);
        @(negedge clk_i);
        addr_load_o = 1'b1;
        addr_o      = a;
        @(negedge clk_i);
        addr_load_o = 1'b0;
        addr_o      = ~a;
    endtask : load
    task put(input logic [7:0] d);
        @(negedge clk_i);
        wr_o    = 1'b1;
        wdata_o = d;
        @(negedge clk_i);
        wr_o    = 1'b0;
        wdata_o = ~d;
    endtask : put
    task get(output logic [7:0] d);
        int n;
        @(negedge clk_i);
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        n    = 0;
        while (rvalid_i !== 1'b1 && n < 4) begin
            @(negedge clk_i);
            n = n + 1;
        end
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
    endtask : get
endmodule : tibc_mcu_model
